// >>> hw/pic_defines.svh
// Purpose: Register indices, field positions and reset values of the PHY interrupt control.
// Assumes: Wishbone byte address is four times the register index.
// Notes: Definitions only.
`ifndef PIC_DEFINES_SVH
`define PIC_DEFINES_SVH

`define PIC_ADR_W 8
`define PIC_IDX_CTRL 6'h11
`define PIC_IDX_STAT 6'h12

`define PIC_CTRL_SCR_BYP 11
`define PIC_CTRL_DEPTH_HI 9
`define PIC_CTRL_DEPTH_LO 8
`define PIC_CTRL_COL_FD 4
`define PIC_CTRL_POL 3
`define PIC_CTRL_TEST 2
`define PIC_CTRL_GEN 1
`define PIC_CTRL_OE 0
`define PIC_CTRL_RST 16'h0108
`define PIC_DEPTH_RST 2'h1

`define PIC_STAT_LINK 13
`define PIC_STAT_SPEED 12
`define PIC_STAT_LINK_EN 5
`define PIC_STAT_SPEED_EN 4

`define PIC_DEPTH_C0 4'h4
`define PIC_DEPTH_C1 4'h5
`define PIC_DEPTH_C2 4'h6
`define PIC_DEPTH_C3 4'h8

`endif

// >>> hw/pic_pkg.sv
// Purpose: Shared types of the PHY interrupt control.
// Assumes: Nothing beyond the defines header.
// Notes: Constants live in pic_defines.svh.
package pic_pkg;
  typedef enum logic [0:0] {
    PIC_LB_FILL,
    PIC_LB_RUN
  } pic_lb_state_e;
endpackage : pic_pkg

// >>> hw/pic_sync.sv
// Purpose: Two-flop synchroniser for asynchronous pin inputs.
// Assumes: Each bit is an independent level.
// Notes: Only the second stage may be read.
`timescale 1ns/10ps
module pic_sync #(
  parameter int W = 1
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);
  logic [W-1:0] stage1_reg;
  logic [W-1:0] stage2_reg;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      // Reset to the pulled-up idle level, so no false low follows reset
      stage1_reg <= '1;
      stage2_reg <= '1;
    end else begin
      stage1_reg <= async_in;
      stage2_reg <= stage1_reg;
    end
  end

  assign sync_out = stage2_reg;
endmodule : pic_sync

// >>> hw/pic_lb_fifo.sv
// Purpose: Far-end loopback nibble FIFO with programmable start depth.
// Assumes: Receive and transmit rates arrive as strobes on clk_sys.
// Notes: Draining starts only once the chosen depth has filled.
`timescale 1ns/10ps
`include "pic_defines.svh"
module pic_lb_fifo #(
  parameter int DEPTH_MAX = 8,
  parameter int PTR_W = 3
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic enable,
  input wire logic [1:0] depth_code,
  input wire logic rx_valid,
  input wire logic [3:0] rx_nibble,
  input wire logic tx_take,
  output logic tx_valid,
  output logic [3:0] tx_nibble,
  output logic overflow,
  output logic underflow
);
  function automatic logic [3:0] depth_of(input logic [1:0] code);
    case (code)
      2'h0: depth_of = `PIC_DEPTH_C0;
      2'h1: depth_of = `PIC_DEPTH_C1;
      2'h2: depth_of = `PIC_DEPTH_C2;
      default: depth_of = `PIC_DEPTH_C3;
    endcase
  endfunction : depth_of

  localparam logic [3:0] FULL_CNT = 4'(DEPTH_MAX);

  logic [3:0] mem [0:DEPTH_MAX-1];
  logic [PTR_W-1:0] wptr_reg;
  logic [PTR_W-1:0] rptr_reg;
  logic [3:0] count_reg;
  pic_pkg::pic_lb_state_e state_reg;
  logic tx_valid_reg;
  logic [3:0] tx_nibble_reg;
  logic ovf_reg;
  logic unf_reg;

  wire logic full = (count_reg == FULL_CNT);
  wire logic empty = (count_reg == 4'h0);
  wire logic push = enable && rx_valid && !full;
  wire logic can_pop = (state_reg == pic_pkg::PIC_LB_RUN) && !empty;
  wire logic pop = enable && tx_take && can_pop;
  wire logic primed = (count_reg >= depth_of(depth_code));

  always_ff @(posedge clk_sys) begin
    if (push) begin
      mem[wptr_reg] <= rx_nibble;
    end
  end

  // Rate difference absorbed: fill to depth, then drain at transmit rate
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      wptr_reg <= '0;
      rptr_reg <= '0;
      count_reg <= 4'h0;
      state_reg <= pic_pkg::PIC_LB_FILL;
      tx_valid_reg <= 1'b0;
      tx_nibble_reg <= 4'h0;
      ovf_reg <= 1'b0;
      unf_reg <= 1'b0;
    end else if (!enable) begin
      wptr_reg <= '0;
      rptr_reg <= '0;
      count_reg <= 4'h0;
      state_reg <= pic_pkg::PIC_LB_FILL;
      tx_valid_reg <= 1'b0;
      ovf_reg <= 1'b0;
      unf_reg <= 1'b0;
    end else begin
      if (push) begin
        wptr_reg <= PTR_W'(wptr_reg + 1'b1);
      end
      if (pop) begin
        rptr_reg <= PTR_W'(rptr_reg + 1'b1);
        tx_nibble_reg <= mem[rptr_reg];
      end
      count_reg <= 4'(count_reg + {3'h0, push} - {3'h0, pop});
      tx_valid_reg <= pop;
      ovf_reg <= rx_valid && full;
      unf_reg <= tx_take && (state_reg == pic_pkg::PIC_LB_RUN) && empty;
      case (state_reg)
        pic_pkg::PIC_LB_FILL: begin
          if (primed) begin
            state_reg <= pic_pkg::PIC_LB_RUN;
          end
        end
        pic_pkg::PIC_LB_RUN: begin
          // Refill after a slip so the margin is restored
          if (tx_take && empty) begin
            state_reg <= pic_pkg::PIC_LB_FILL;
          end
        end
        default: state_reg <= pic_pkg::PIC_LB_FILL;
      endcase
    end
  end

  assign tx_valid = tx_valid_reg;
  assign tx_nibble = tx_nibble_reg;
  assign overflow = ovf_reg;
  assign underflow = unf_reg;
endmodule : pic_lb_fifo

// >>> hw/pic_top.sv
// Purpose: PHY special control and first interrupt status registers with interrupt pin.
// Assumes: Classic Wishbone slave, 32-bit data, registers in the low 16 bits.
// Notes: Event pulses and collision come from logic on clk_sys.
//
// Contract
// - Control bit 11 set bypasses the transmit scrambler; resets to zero.
// - Reserved control bits 10, 7:5 and status 15:14 read zero, ignore writes.
// - Bits 9:8 pick loopback depth 4, 5, 6 or 8 nibbles; reset 01.
// - Loopback FIFO absorbs receive versus transmit rate difference.
// - Bit 4 set allows collision in full duplex; otherwise half duplex only.
// - Polarity bit 3 resets one; one idles high, low when active.
// - Self-test bit 2 forces an interrupt regardless of events.
// - Forced interrupt stays asserted while the self-test bit stays set.
// - Global enable bit 1 permits event interrupts under per-event enables.
// - Bit 0 one drives the shared pin as interrupt, zero power-down input.
// - A status bit sets when its event occurred since the last read.
// - An event interrupts only when its own enable bit is set.
// - Status bits record events whether or not enabled.
// - Bit 13 flags link change, read-only, clears on read, resets zero.
// - Bit 12 flags speed change, read-only, clears on read, resets zero.
// - Enable bit 5 gates the link change interrupt; resets zero.
// - Enable bit 4 gates the speed change interrupt; resets zero.
`timescale 1ns/10ps
`include "pic_defines.svh"
module pic_top #(
  parameter int LB_DEPTH_MAX = 8
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [`PIC_ADR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic link_change_pulse,
  input wire logic speed_change_pulse,
  input wire logic col_raw,
  input wire logic full_duplex,
  output logic scr_bypass,
  output logic col_out,
  input wire logic lb_enable,
  input wire logic lb_rx_valid,
  input wire logic [3:0] lb_rx_nibble,
  input wire logic lb_tx_take,
  output logic lb_tx_valid,
  output logic [3:0] lb_tx_nibble,
  output logic lb_overflow,
  output logic lb_underflow,
  input wire logic irq_or_powerdown_pin_i,
  output logic irq_or_powerdown_pin_o,
  output logic irq_or_powerdown_pin_oe,
  output logic powerdown
);
  // Reset image of the control word, so single bits can be picked from it
  localparam logic [15:0] CTRL_RST = `PIC_CTRL_RST;

  // Control register fields
  logic scr_bypass_reg;
  logic [1:0] lb_depth_reg;
  logic collision_in_full_duplex_reg;
  logic irq_polarity_reg;
  logic test_irq_reg;
  logic irq_global_en_reg;
  logic irq_pin_sel_reg;

  // Status register fields
  logic link_chg_reg;
  logic speed_chg_reg;
  logic link_chg_en_reg;
  logic speed_chg_en_reg;

  // Bus and output flops
  logic ack_reg;
  logic [31:0] rdata_reg;
  logic col_out_reg;
  logic pin_o_reg;
  logic pin_oe_reg;
  logic powerdown_reg;

  logic pin_sync;
  logic link_chg_next;
  logic speed_chg_next;

  // Bus decode
  wire logic [5:0] reg_idx = wb_adr_i[`PIC_ADR_W-1:2];
  wire logic req = wb_cyc_i && wb_stb_i;
  wire logic req_start = req && !ack_reg;
  wire logic req_done = req && ack_reg;
  wire logic hit_ctrl = (reg_idx == `PIC_IDX_CTRL);
  wire logic hit_stat = (reg_idx == `PIC_IDX_STAT);
  wire logic wr_lo = req_done && wb_we_i && wb_sel_i[0];
  wire logic wr_hi = req_done && wb_we_i && wb_sel_i[1];
  wire logic wr_ctrl_lo = wr_lo && hit_ctrl;
  wire logic wr_ctrl_hi = wr_hi && hit_ctrl;
  wire logic wr_stat_lo = wr_lo && hit_stat;
  // Cleared when data is captured, so nothing arriving later is lost
  wire logic rd_stat = req_start && !wb_we_i && hit_stat;

  // Reserved positions are constant zero in the read images
  wire logic [15:0] ctrl_image = {
    4'h0,
    scr_bypass_reg,
    1'b0,
    lb_depth_reg,
    3'h0,
    collision_in_full_duplex_reg,
    irq_polarity_reg,
    test_irq_reg,
    irq_global_en_reg,
    irq_pin_sel_reg
  };
  wire logic [15:0] stat_image = {
    2'h0,
    link_chg_reg,
    speed_chg_reg,
    6'h00,
    link_chg_en_reg,
    speed_chg_en_reg,
    4'h0
  };
  wire logic [15:0] rd_sel = hit_ctrl ? ctrl_image : (hit_stat ? stat_image : 16'h0000);

  // Interrupt condition
  wire logic link_irq = link_chg_reg && link_chg_en_reg;
  wire logic speed_irq = speed_chg_reg && speed_chg_en_reg;
  wire logic event_irq = irq_global_en_reg && (link_irq || speed_irq);
  wire logic irq_active = event_irq || test_irq_reg;
  wire logic pin_level = irq_polarity_reg ? !irq_active : irq_active;

  // Collision gate
  wire logic col_allowed = !full_duplex || collision_in_full_duplex_reg;

  // Set wins over clear on read; recorded regardless of enables
  always_comb begin
    link_chg_next = (link_chg_reg && !rd_stat) || link_change_pulse;
    speed_chg_next = (speed_chg_reg && !rd_stat) || speed_change_pulse;
  end

  // Wishbone slave: answer one cycle after the request, unmapped reads zero
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ack_reg <= 1'b0;
      rdata_reg <= 32'h0000_0000;
    end else begin
      ack_reg <= req_start;
      if (req_start) begin
        rdata_reg <= {16'h0000, rd_sel};
      end
    end
  end

  // Control register low byte
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      collision_in_full_duplex_reg <= CTRL_RST[`PIC_CTRL_COL_FD];
      irq_polarity_reg <= CTRL_RST[`PIC_CTRL_POL];
      test_irq_reg <= CTRL_RST[`PIC_CTRL_TEST];
      irq_global_en_reg <= CTRL_RST[`PIC_CTRL_GEN];
      irq_pin_sel_reg <= CTRL_RST[`PIC_CTRL_OE];
    end else if (wr_ctrl_lo) begin
      collision_in_full_duplex_reg <= wb_dat_i[`PIC_CTRL_COL_FD];
      irq_polarity_reg <= wb_dat_i[`PIC_CTRL_POL];
      // Held until software itself writes zero
      test_irq_reg <= wb_dat_i[`PIC_CTRL_TEST];
      irq_global_en_reg <= wb_dat_i[`PIC_CTRL_GEN];
      irq_pin_sel_reg <= wb_dat_i[`PIC_CTRL_OE];
    end
  end

  // Control register high byte
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      scr_bypass_reg <= CTRL_RST[`PIC_CTRL_SCR_BYP];
      lb_depth_reg <= `PIC_DEPTH_RST;
    end else if (wr_ctrl_hi) begin
      scr_bypass_reg <= wb_dat_i[`PIC_CTRL_SCR_BYP];
      lb_depth_reg <= wb_dat_i[`PIC_CTRL_DEPTH_HI:`PIC_CTRL_DEPTH_LO];
    end
  end

  // Status register: enables writable, pending flags read-only
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      link_chg_en_reg <= 1'b0;
      speed_chg_en_reg <= 1'b0;
    end else if (wr_stat_lo) begin
      link_chg_en_reg <= wb_dat_i[`PIC_STAT_LINK_EN];
      speed_chg_en_reg <= wb_dat_i[`PIC_STAT_SPEED_EN];
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      link_chg_reg <= 1'b0;
      speed_chg_reg <= 1'b0;
    end else begin
      link_chg_reg <= link_chg_next;
      speed_chg_reg <= speed_chg_next;
    end
  end

  // Shared pin: interrupt output or active-low power-down input
  pic_sync #(
    .W(1)
  ) u_pin_sync (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .async_in(irq_or_powerdown_pin_i),
    .sync_out(pin_sync)
  );

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      pin_o_reg <= 1'b1;
      pin_oe_reg <= 1'b0;
      powerdown_reg <= 1'b0;
      col_out_reg <= 1'b0;
    end else begin
      pin_o_reg <= pin_level;
      pin_oe_reg <= irq_pin_sel_reg;
      // Power-down only sensed while the pin is an input
      powerdown_reg <= !irq_pin_sel_reg && !pin_sync;
      col_out_reg <= col_raw && col_allowed;
    end
  end

  // Far-end loopback buffer
  pic_lb_fifo #(
    .DEPTH_MAX(LB_DEPTH_MAX),
    .PTR_W($clog2(LB_DEPTH_MAX))
  ) u_lb_fifo (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .enable(lb_enable),
    .depth_code(lb_depth_reg),
    .rx_valid(lb_rx_valid),
    .rx_nibble(lb_rx_nibble),
    .tx_take(lb_tx_take),
    .tx_valid(lb_tx_valid),
    .tx_nibble(lb_tx_nibble),
    .overflow(lb_overflow),
    .underflow(lb_underflow)
  );

  assign wb_dat_o = rdata_reg;
  assign wb_ack_o = ack_reg;
  assign scr_bypass = scr_bypass_reg;
  assign col_out = col_out_reg;
  assign irq_or_powerdown_pin_o = pin_o_reg;
  assign irq_or_powerdown_pin_oe = pin_oe_reg;
  assign powerdown = powerdown_reg;
endmodule : pic_top

// >>> verification/pic_top_properties.sv
// Purpose: Port-level checks of the PHY interrupt control.
// Assumes: Shadow copies follow acked Wishbone writes and taken reads.
// Notes: Output checks wait until the control and status shadows have been stable two edges.
`timescale 1ns/10ps
`include "pic_defines.svh"
module pic_top_properties (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [`PIC_ADR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic link_change_pulse,
  input wire logic speed_change_pulse,
  input wire logic col_raw,
  input wire logic full_duplex,
  input wire logic scr_bypass,
  input wire logic col_out,
  input wire logic irq_or_powerdown_pin_o,
  input wire logic irq_or_powerdown_pin_oe,
  input wire logic powerdown
);
  logic [15:0] sh;
  logic [15:0] sh_q;
  logic [15:0] rexp;
  logic [1:0] pend;
  logic [1:0] en;
  logic [3:0] st_q;
  logic [1:0] age;
  wire logic [5:0] idx = wb_adr_i[7:2];
  wire logic take = wb_cyc_i && wb_stb_i && !wb_ack_o;
  wire logic wr_ack = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o;
  wire logic rd_st = take && !wb_we_i && idx == `PIC_IDX_STAT;
  wire logic [15:0] st_word = {2'h0, pend, 6'h00, en, 4'h0};
  wire logic act = sh[2] || (sh[1] && |(pend & en));
  // Outputs lag their cause by a register, so look only once it settled
  wire logic quiet = sh == sh_q && {pend, en} == st_q && age != 2'h0;
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      sh <= `PIC_CTRL_RST;
      sh_q <= `PIC_CTRL_RST;
      rexp <= 16'h0000;
      pend <= 2'h0;
      en <= 2'h0;
      st_q <= 4'h0;
      age <= 2'h0;
    end else begin
      if (wr_ack && idx == `PIC_IDX_CTRL && wb_sel_i[0]) sh[7:0] <= wb_dat_i[7:0] & 8'h1F;
      if (wr_ack && idx == `PIC_IDX_CTRL && wb_sel_i[1]) sh[15:8] <= wb_dat_i[15:8] & 8'h0B;
      if (wr_ack && idx == `PIC_IDX_STAT && wb_sel_i[0]) en <= wb_dat_i[5:4];
      // Set wins over the clear of a read in the same cycle
      pend <= (rd_st ? 2'h0 : pend) | {link_change_pulse, speed_change_pulse};
      if (take) rexp <= idx == `PIC_IDX_CTRL ? sh : (idx == `PIC_IDX_STAT ? st_word : 16'h0000);
      sh_q <= sh;
      st_q <= {pend, en};
      age <= (sh != sh_q || {pend, en} != st_q) ? 2'h0 : (age == 2'h3 ? age : age + 2'h1);
    end
  end
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  property p_ack; take |=> wb_ack_o ##1 !wb_ack_o; endproperty
  a_ack: assert property (p_ack) else $error("ack is not a one-cycle answer");
  property p_read; wb_ack_o && !wb_we_i |-> wb_dat_o == {16'h0000, rexp}; endproperty
  a_read: assert property (p_read) else $error("read data wrong");
  property p_scr; quiet |-> scr_bypass == sh[11]; endproperty
  a_scr: assert property (p_scr) else $error("scrambler bypass wrong");
  property p_col; quiet |-> col_out == $past(col_raw && (!full_duplex || sh[4])); endproperty
  a_col: assert property (p_col) else $error("collision output wrong");
  property p_oe; quiet |-> irq_or_powerdown_pin_oe == sh[0]; endproperty
  a_oe: assert property (p_oe) else $error("pin enable wrong");
  property p_pin; quiet |-> irq_or_powerdown_pin_o == (sh[3] ^ act); endproperty
  a_pin: assert property (p_pin) else $error("pin level wrong");
  property p_test; quiet && sh[2] |-> irq_or_powerdown_pin_o == !sh[3]; endproperty
  a_test: assert property (p_test) else $error("test interrupt missing");
  property p_gen; quiet && !sh[1] && !sh[2] |-> irq_or_powerdown_pin_o == sh[3]; endproperty
  a_gen: assert property (p_gen) else $error("interrupt without global enable");
  property p_pwd; quiet && sh[0] |-> !powerdown; endproperty
  a_pwd: assert property (p_pwd) else $error("power-down while pin is output");
endmodule : pic_top_properties

bind pic_top pic_top_properties u_props (
  .clk_sys, .rst_n, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i,
  .wb_dat_o, .wb_ack_o, .link_change_pulse, .speed_change_pulse, .col_raw, .full_duplex,
  .scr_bypass, .col_out, .irq_or_powerdown_pin_o, .irq_or_powerdown_pin_oe, .powerdown
);

// >>> verification/pic_host_model.sv
// Purpose: Station management host issuing classic Wishbone cycles.
// Assumes: Called at any time; it aligns itself to a rising edge.
// Notes: A wait without ack ends the run through the bench.
`timescale 1ns/10ps
module pic_host_model (
  input wire logic clk_sys,
  input wire logic ack,
  output logic cyc,
  output logic stb,
  output logic we,
  output logic [7:0] adr,
  output logic [3:0] sel,
  output logic [31:0] dat
);
  initial begin
    cyc = 1'b0;
    stb = 1'b0;
    we = 1'b0;
    adr = 8'h00;
    sel = 4'h0;
    dat = 32'h00000000;
  end
  task automatic xfer(input logic w, input logic [7:0] a, input logic [15:0] d,
                      input logic [3:0] s);
    int n;
    @(posedge clk_sys);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    sel <= s;
    dat <= {16'h0000, d};
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (ack !== 1'b1 && n < 20);
    if (n >= 20) begin
      tb_top.mismatches++;
      tb_top.test_done();
    end
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask : xfer
endmodule : pic_host_model

// >>> verification/tb_top.sv
// Purpose: Self-checking bench of the PHY interrupt control.
// Assumes: Read results are queued by the driver and popped at ack.
// Notes: Output levels are sampled at the falling edge.
`timescale 1ns/10ps
module tb_top;
  localparam logic [7:0] A_CTRL = 8'h44;
  localparam logic [7:0] A_STAT = 8'h48;
  logic clk_sys, rst_n, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, link_p, speed_p;
  logic col_raw, full_duplex, scr_bypass, col_out, lb_enable, lb_rx_valid, lb_tx_take;
  logic lb_tx_valid, pin_i, pin_o, pin_oe, powerdown, lb_ovf, lb_unf;
  logic [7:0] wb_adr_i;
  logic [3:0] wb_sel_i, lb_rx_nibble, lb_tx_nibble;
  logic [31:0] wb_dat_i, wb_dat_o;
  logic [15:0] exp_q[$];
  logic [15:0] d;
  int mismatches, cmp_count;
  int dep[4] = '{4, 5, 6, 8};
  initial begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end
  pic_host_model u_host (.clk_sys(clk_sys), .ack(wb_ack_o), .cyc(wb_cyc_i), .stb(wb_stb_i),
    .we(wb_we_i), .adr(wb_adr_i), .sel(wb_sel_i), .dat(wb_dat_i));
  pic_top u_dut (.clk_sys(clk_sys), .rst_n(rst_n), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .link_change_pulse(link_p),
    .speed_change_pulse(speed_p), .col_raw(col_raw), .full_duplex(full_duplex),
    .scr_bypass(scr_bypass), .col_out(col_out), .lb_enable(lb_enable),
    .lb_rx_valid(lb_rx_valid), .lb_rx_nibble(lb_rx_nibble), .lb_tx_take(lb_tx_take),
    .lb_tx_valid(lb_tx_valid), .lb_tx_nibble(lb_tx_nibble), .lb_overflow(lb_ovf),
    .lb_underflow(lb_unf), .irq_or_powerdown_pin_i(pin_i), .irq_or_powerdown_pin_o(pin_o),
    .irq_or_powerdown_pin_oe(pin_oe), .powerdown(powerdown));
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check
  task automatic test_done();
    $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : test_done
  task automatic wr(input logic [7:0] a, input logic [15:0] v, input logic [3:0] s);
    u_host.xfer(1'b1, a, v, s);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [15:0] e);
    exp_q.push_back(e);
    u_host.xfer(1'b0, a, 16'h0000, 4'hF);
  endtask : rd
  task automatic settle();
    repeat (3) @(posedge clk_sys);
    @(negedge clk_sys);
  endtask : settle
  task automatic drive_ev(input logic l, input logic s);
    @(posedge clk_sys);
    link_p <= l;
    speed_p <= s;
    @(posedge clk_sys);
    link_p <= 1'b0;
    speed_p <= 1'b0;
    settle();
  endtask : drive_ev
  // Read data is only valid in the ack cycle
  always @(posedge clk_sys) begin
    if (wb_ack_o === 1'b1 && wb_we_i === 1'b0) begin
      if (exp_q.size() == 0) check("spare read", 32'h1, 32'h0);
      else check("read data", wb_dat_o, {16'h0000, exp_q.pop_front()});
    end
  end
  initial begin
    {rst_n, link_p, speed_p, col_raw, full_duplex, lb_enable, lb_rx_valid, lb_tx_take} = 8'h00;
    lb_rx_nibble = 4'h0;
    pin_i = 1'b1;
    void'($urandom(32'h8DB73CA8));
    repeat (12) @(posedge clk_sys);
    rst_n <= 1'b1;
    rd(A_CTRL, 16'h0108);
    rd(A_STAT, 16'h0000);
    settle();
    check("pin idle", {pin_o, pin_oe}, 2'b10);
    for (int i = 0; i < 4; i++) begin
      d = 16'($urandom);
      wr(A_CTRL, d, 4'hF);
      rd(A_CTRL, d & 16'h0B1F);
      wr(A_CTRL, ~d, 4'h2);
      rd(A_CTRL, {~d[15:8] & 8'h0B, d[7:0] & 8'h1F});
      settle();
      check("scr_bypass", scr_bypass, 1'(~d[11]));
    end
    wr(8'h4C, 16'hFFFF, 4'hF);
    rd(8'h4C, 16'h0000);
    for (int c = 0; c < 4; c++) begin
      wr(A_CTRL, {6'h00, 2'(c), 8'h08}, 4'hF);
      rd(A_CTRL, {6'h00, 2'(c), 8'h08});
      lb_enable <= 1'b1;
      for (int k = 0; k < dep[c]; k++) begin
        lb_rx_valid <= 1'b1;
        lb_rx_nibble <= 4'(k + 1);
        lb_tx_take <= (k == dep[c] - 1);
        @(posedge clk_sys);
      end
      lb_rx_valid <= 1'b0;
      lb_tx_take <= 1'b0;
      @(negedge clk_sys);
      check("tx before depth", lb_tx_valid, 1'b0);
      @(posedge clk_sys);
      lb_tx_take <= 1'b1;
      @(posedge clk_sys);
      lb_tx_take <= 1'b0;
      @(negedge clk_sys);
      check("tx at depth", {lb_tx_valid, lb_tx_nibble}, 5'h11);
      @(posedge clk_sys);
      lb_enable <= 1'b0;
    end
    // Depth code 3 still set: fill past eight, then drain past empty
    @(posedge clk_sys);
    lb_enable <= 1'b1;
    lb_rx_valid <= 1'b1;
    repeat (9) @(posedge clk_sys);
    lb_rx_valid <= 1'b0;
    @(negedge clk_sys);
    check("overflow", lb_ovf, 1'b1);
    @(posedge clk_sys);
    lb_tx_take <= 1'b1;
    repeat (9) @(posedge clk_sys);
    lb_tx_take <= 1'b0;
    @(negedge clk_sys);
    check("underflow", lb_unf, 1'b1);
    @(posedge clk_sys);
    lb_enable <= 1'b0;
    wr(A_CTRL, 16'h000D, 4'hF);
    settle();
    check("test irq", {pin_o, pin_oe}, 2'b01);
    settle();
    check("test irq held", pin_o, 1'b0);
    wr(A_CTRL, 16'h0005, 4'hF);
    settle();
    check("test irq low pol", pin_o, 1'b1);
    wr(A_STAT, 16'hFFFF, 4'hF);
    rd(A_STAT, 16'h0030);
    wr(A_CTRL, 16'h000B, 4'hF);
    drive_ev(1'b1, 1'b0);
    check("link irq", pin_o, 1'b0);
    rd(A_STAT, 16'h2030);
    settle();
    check("irq after read", pin_o, 1'b1);
    wr(A_STAT, 16'h0020, 4'hF);
    drive_ev(1'b0, 1'b1);
    check("masked speed", pin_o, 1'b1);
    rd(A_STAT, 16'h1020);
    wr(A_CTRL, 16'h0009, 4'hF);
    drive_ev(1'b1, 1'b0);
    check("no global", pin_o, 1'b1);
    rd(A_STAT, 16'h2020);
    wr(A_CTRL, 16'h0008, 4'hF);
    pin_i <= 1'b0;
    settle();
    check("powerdown", {pin_oe, powerdown}, 2'b01);
    for (int m = 0; m < 4; m++) begin
      wr(A_CTRL, {11'h001, m[1], 4'h0}, 4'hF);
      full_duplex <= m[0];
      col_raw <= 1'b1;
      settle();
      check("collision", col_out, !m[0] || m[1]);
    end
    settle();
    check("reads left", exp_q.size(), 32'h0);
    test_done();
  end
endmodule : tb_top
